// *** verilog/i2c_target_consts.svh ***
// Constants of the two-wire target interface with strap-set address
`ifndef I2C_TARGET_CONSTS_SVH
`define I2C_TARGET_CONSTS_SVH

`define BITS_PER_BYTE     4'h8
`define BIT_COUNT_RESET   4'h0
`define BIT_COUNT_STEP    4'h1
`define PTR_STEP          8'h01
`define PTR_RESET         8'h00
`define BYTE_RESET        8'h00
`define MSB_POS           7
`define DIR_BIT_POS       0
`define DIR_READ          1'b1
`define ADDR_FIXED_HI     4'hc
`define ADDR_LOW_W        3
`define SDA_DRIVE_LEVEL   1'b0
`define PIN_IDLE          1'b1

// Strap connection classes
`define STRAP_GND         2'h0
`define STRAP_RAIL        2'h1
`define STRAP_SCL         2'h2
`define STRAP_SDA         2'h3

// Low address bits for each strap pair {strap_1, strap_0}
`define LOW_GND_RAIL      3'h1
`define LOW_RAIL_GND      3'h2
`define LOW_RAIL_RAIL     3'h3
`define LOW_RAIL_SCL      3'h4
`define LOW_RAIL_SDA      3'h5
`define LOW_SCL_RAIL      3'h6
`define LOW_SDA_RAIL      3'h7
`define LOW_NONE          3'h0

`endif

// *** verilog/i2c_target_pkg.sv ***
// Types of the two-wire target interface
package i2c_target_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RECV = 3'h1,
		ST_ACK  = 3'h3,
		ST_SEND = 3'h2,
		ST_RACK = 3'h6
	} link_state_e;

	typedef enum logic [1:0] {
		PH_SLAVE_ADDR = 2'h0,
		PH_REG_ADDR   = 2'h1,
		PH_DATA       = 2'h3
	} byte_phase_e;

	typedef logic [1:0] strap_class_t;

endpackage

// *** verilog/i2c_target_strap_address.sv ***
// Two-wire serial target: framing, strap address decode, register access
//
// Notes on behaviour
// - One bit per SCL rise, SDA steady
// - SDA change while SCL high is control
// - Idle: both lines released high
// - SDA fall with SCL high starts transfer
// - SDA rise with SCL high ends transfer
// - Repeated START restarts address parsing
// - After STOP or mismatch, ignore until START
// - Pull SDA low through ninth clock
// - Seven address bits MSB first, then direction
// - First byte after START is address
// - Two straps pick address or stand-alone
// - Single write: address, register, one data
// - Burst write: data bytes until master ends
// - Single read: address, register, Sr, one byte
// - Burst read continues until master NACK
`timescale 1ns/100ps
`include "i2c_target_consts.svh"

module i2c_target_strap_address
	import i2c_target_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       slave_id_strap_0,
	input  wire logic       slave_id_strap_1,
	output logic            standalone_mode,
	output logic            session_active,
	output logic [7:0]      reg_addr,
	output logic [7:0]      wr_data,
	output logic            wr_strobe,
	input  wire logic [7:0] rd_data,
	output logic            rd_strobe
);

	// Two-stage synchronisers, third stage for edge finding
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] st0_sync;
	logic [1:0] st1_sync;
	logic       scl_q;
	logic       sda_q;
	logic       st0_q;
	logic       st1_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			scl_sync <= {2{`PIN_IDLE}};
			sda_sync <= {2{`PIN_IDLE}};
			st0_sync <= {2{`PIN_IDLE}};
			st1_sync <= {2{`PIN_IDLE}};
			scl_q    <= `PIN_IDLE;
			sda_q    <= `PIN_IDLE;
			st0_q    <= `PIN_IDLE;
			st1_q    <= `PIN_IDLE;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			st0_sync <= {st0_sync[0], slave_id_strap_0};
			st1_sync <= {st1_sync[0], slave_id_strap_1};
			scl_q    <= scl_sync[1];
			sda_q    <= sda_sync[1];
			st0_q    <= st0_sync[1];
			st1_q    <= st1_sync[1];
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	assign scl_s      = scl_sync[1];
	assign sda_s      = sda_sync[1];
	assign scl_rise   = scl_s & ~scl_q;
	assign scl_fall   = ~scl_s & scl_q;
	assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;

	// Strap classing: a strap tied to a bus line follows it; one tied to
	// ground is seen low while that line is high. Compared only while all
	// inputs are stable, since sampling skew at edges would misclass.
	logic [1:0] seen_low;
	logic [1:0] off_scl;
	logic [1:0] off_sda;
	logic [1:0] next_seen_low;
	logic [1:0] next_off_scl;
	logic [1:0] next_off_sda;
	logic [1:0] strap_now;
	logic       quiet;

	assign strap_now = {st1_sync[1], st0_sync[1]};

	always_comb begin
		next_seen_low = seen_low;
		next_off_scl  = off_scl;
		next_off_sda  = off_sda;
		quiet = (scl_s == scl_q) && (sda_s == sda_q)
			&& (strap_now == {st1_q, st0_q});
		if (quiet) begin
			next_seen_low = seen_low | ~strap_now;
			next_off_scl  = off_scl | (strap_now ^ {2{scl_s}});
			next_off_sda  = off_sda | (strap_now ^ {2{sda_s}});
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			seen_low <= 2'h0;
			off_scl  <= 2'h0;
			off_sda  <= 2'h0;
		end else begin
			seen_low <= next_seen_low;
			off_scl  <= next_off_scl;
			off_sda  <= next_off_sda;
		end
	end

	function automatic strap_class_t class_of(input logic low,
		input logic o_scl, input logic o_sda);
		if (!low)
			class_of = `STRAP_RAIL;
		else if (!o_scl)
			class_of = `STRAP_SCL;
		else if (!o_sda)
			class_of = `STRAP_SDA;
		else
			class_of = `STRAP_GND;
	endfunction

	function automatic logic [`ADDR_LOW_W-1:0] low_bits(
		input strap_class_t c1, input strap_class_t c0);
		case ({c1, c0})
			{`STRAP_GND,  `STRAP_RAIL}: low_bits = `LOW_GND_RAIL;
			{`STRAP_RAIL, `STRAP_GND }: low_bits = `LOW_RAIL_GND;
			{`STRAP_RAIL, `STRAP_RAIL}: low_bits = `LOW_RAIL_RAIL;
			{`STRAP_RAIL, `STRAP_SCL }: low_bits = `LOW_RAIL_SCL;
			{`STRAP_RAIL, `STRAP_SDA }: low_bits = `LOW_RAIL_SDA;
			{`STRAP_SCL,  `STRAP_RAIL}: low_bits = `LOW_SCL_RAIL;
			{`STRAP_SDA,  `STRAP_RAIL}: low_bits = `LOW_SDA_RAIL;
			default:                    low_bits = `LOW_NONE;
		endcase
	endfunction

	strap_class_t           cls0;
	strap_class_t           cls1;
	logic [`ADDR_LOW_W-1:0] addr_low;
	logic [6:0]             own_addr;
	logic                   no_addr;

	assign cls0     = class_of(seen_low[0], off_scl[0], off_sda[0]);
	assign cls1     = class_of(seen_low[1], off_scl[1], off_sda[1]);
	assign addr_low = low_bits(cls1, cls0);
	assign own_addr = {`ADDR_FIXED_HI, addr_low};
	// Unlisted strap pairs leave the serial port unused as well
	assign no_addr  = (addr_low == `LOW_NONE);

	// Link engine
	link_state_e state;
	link_state_e next_state;
	byte_phase_e phase;
	byte_phase_e next_phase;
	logic [3:0]  bit_cnt;
	logic [3:0]  next_bit_cnt;
	logic [7:0]  shift;
	logic [7:0]  next_shift;
	logic [7:0]  next_reg_addr;
	logic [7:0]  next_wr_data;
	logic        next_wr_strobe;
	logic        next_rd_strobe;
	logic        read_dir;
	logic        next_read_dir;
	logic        master_ack;
	logic        next_master_ack;
	logic        next_sda_oe;
	logic        next_standalone;

	always_comb begin
		next_state      = state;
		next_phase      = phase;
		next_bit_cnt    = bit_cnt;
		next_shift      = shift;
		next_reg_addr   = reg_addr;
		next_wr_data    = wr_data;
		next_wr_strobe  = 1'b0;
		next_rd_strobe  = 1'b0;
		next_read_dir   = read_dir;
		next_master_ack = master_ack;
		next_sda_oe     = 1'b0;
		next_standalone = no_addr;
		if (stop_seen) begin
			next_state = ST_IDLE;
		end else if (start_seen && !no_addr) begin
			next_state   = ST_RECV;
			next_phase   = PH_SLAVE_ADDR;
			next_bit_cnt = `BIT_COUNT_RESET;
		end else begin
			case (state)
				ST_IDLE: begin
					next_state = ST_IDLE;
				end
				ST_RECV: begin
					if (scl_rise && bit_cnt != `BITS_PER_BYTE) begin
						next_shift   = {shift[6:0], sda_s};
						next_bit_cnt = bit_cnt + `BIT_COUNT_STEP;
					end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
						next_state  = ST_ACK;
						next_sda_oe = 1'b1;
						case (phase)
							PH_SLAVE_ADDR: begin
								next_read_dir =
									(shift[`DIR_BIT_POS] == `DIR_READ);
								if (shift[7:1] != own_addr) begin
									next_state  = ST_IDLE;
									next_sda_oe = 1'b0;
								end
							end
							PH_REG_ADDR: begin
								next_reg_addr = shift;
							end
							default: begin
								next_wr_data   = shift;
								next_wr_strobe = 1'b1;
							end
						endcase
					end
				end
				ST_ACK: begin
					next_sda_oe = 1'b1;
					if (scl_fall) begin
						next_bit_cnt = `BIT_COUNT_RESET;
						next_sda_oe  = 1'b0;
						// Phase moves here so a write steps the pointer only after data; a read steps it on every fetch
						case (phase)
							PH_SLAVE_ADDR: next_phase = PH_REG_ADDR;
							PH_REG_ADDR:   next_phase = PH_DATA;
							default: begin
								if (!read_dir)
									next_reg_addr = reg_addr + `PTR_STEP;
							end
						endcase
						if (read_dir) begin
							next_state     = ST_SEND;
							next_shift     = rd_data;
							next_rd_strobe = 1'b1;
							next_reg_addr  = reg_addr + `PTR_STEP;
							next_sda_oe    = ~rd_data[`MSB_POS];
						end else begin
							next_state = ST_RECV;
						end
					end
				end
				ST_SEND: begin
					next_sda_oe = ~shift[`MSB_POS];
					if (scl_fall) begin
						next_shift   = {shift[6:0], 1'b0};
						next_bit_cnt = bit_cnt + `BIT_COUNT_STEP;
						next_sda_oe  = ~shift[6];
						if (bit_cnt + `BIT_COUNT_STEP == `BITS_PER_BYTE) begin
							next_state  = ST_RACK;
							next_sda_oe = 1'b0;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise)
						next_master_ack = ~sda_s;
					if (scl_fall) begin
						next_bit_cnt = `BIT_COUNT_RESET;
						if (master_ack) begin
							next_state     = ST_SEND;
							next_shift     = rd_data;
							next_rd_strobe = 1'b1;
							next_reg_addr  = reg_addr + `PTR_STEP;
							next_sda_oe    = ~rd_data[`MSB_POS];
						end else begin
							next_state = ST_IDLE;
						end
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state           <= ST_IDLE;
			phase           <= PH_SLAVE_ADDR;
			bit_cnt         <= `BIT_COUNT_RESET;
			shift           <= `BYTE_RESET;
			reg_addr        <= `PTR_RESET;
			wr_data         <= `BYTE_RESET;
			wr_strobe       <= 1'b0;
			rd_strobe       <= 1'b0;
			read_dir        <= 1'b0;
			master_ack      <= 1'b0;
			sda_oe          <= 1'b0;
			standalone_mode <= 1'b0;
		end else begin
			state           <= next_state;
			phase           <= next_phase;
			bit_cnt         <= next_bit_cnt;
			shift           <= next_shift;
			reg_addr        <= next_reg_addr;
			wr_data         <= next_wr_data;
			wr_strobe       <= next_wr_strobe;
			rd_strobe       <= next_rd_strobe;
			read_dir        <= next_read_dir;
			master_ack      <= next_master_ack;
			sda_oe          <= next_sda_oe;
			standalone_mode <= next_standalone;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out        = `SDA_DRIVE_LEVEL;
	assign session_active = (state != ST_IDLE);

endmodule // i2c_target_strap_address

// *** sim/i2c_target_monitor.sv ***
// Port checks for the strap-addressed two-wire target
`timescale 1ns/100ps
module i2c_target_monitor (
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_oe,
	input wire logic       standalone_mode,
	input wire logic       session_active,
	input wire logic [7:0] reg_addr,
	input wire logic       wr_strobe,
	input wire logic       rd_strobe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	AST_WR_PULSE:
		assert property (wr_strobe |=> !wr_strobe)
		else $error("write strobe wider than one cycle");
	AST_RD_PULSE:
		assert property (rd_strobe |=> !rd_strobe)
		else $error("read strobe wider than one cycle");
	AST_RD_STEP:
		assert property (rd_strobe |-> reg_addr == $past(reg_addr) + 8'h01)
		else $error("pointer not advanced on read");
	AST_WR_HOLD:
		assert property (wr_strobe |=> $stable(reg_addr)[*8])
		else $error("pointer moved right after write");
	AST_ALONE_QUIET:
		assert property (standalone_mode |-> !sda_oe && !wr_strobe && !rd_strobe)
		else $error("activity in stand-alone mode");
	AST_IDLE_QUIET:
		assert property (!session_active |-> !sda_oe)
		else $error("SDA pulled outside a session");
	AST_SDA_SCL_LOW:
		assert property ($changed(sda_oe) |-> !scl_in)
		else $error("SDA changed while SCL high");
	AST_START_SEEN:
		assert property ($rose(session_active) |-> scl_in && !sda_in)
		else $error("session opened without START");
endmodule // i2c_target_monitor
bind i2c_target_strap_address i2c_target_monitor i_i2c_target_monitor (
	.sys_clk, .nrst, .scl_in, .sda_in, .sda_oe, .standalone_mode,
	.session_active, .reg_addr, .wr_strobe, .rd_strobe);

// *** sim/master_bfm.sv ***
// Two-wire bus master model with pulled-up SDA
`timescale 1ns/100ps
module master_bfm (
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda_line
);
	logic sda_m;
	// Released line floats to the pull-up level
	assign sda_line = sda_m & ~sda_oe;
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic start();
		#20 sda_m = 1'b1;
		#20 scl = 1'b1;
		#20 sda_m = 1'b0;
		#20 scl = 1'b0;
	endtask
	task automatic stop();
		#20 sda_m = 1'b0;
		#20 scl = 1'b1;
		#20 sda_m = 1'b1;
	endtask
	task automatic xfer(input logic [7:0] d, input logic mack,
			output logic [7:0] r, output logic a);
		for (int i = 7; i >= -1; i--) begin
			#20 sda_m = (i < 0) ? mack : d[i];
			#20 scl = 1'b1;
			#20 if (i >= 0) r[i] = sda_line; else a = ~sda_line;
			#20 scl = 1'b0;
		end
	endtask
endmodule // master_bfm

// *** sim/tb.sv ***
// Self-checking bench of the strap-addressed two-wire target
`timescale 1ns/100ps
`include "i2c_target_consts.svh"
module tb;
	logic       sys_clk, nrst, scl, sda, sda_out, sda_oe, a;
	logic       strap_0, strap_1, standalone_mode, session_active;
	logic       wr_strobe, rd_strobe;
	logic [7:0] reg_addr, wr_data, rd_data, r;
	logic [1:0] cls0, cls1;
	logic [7:0] mem [256];
	int         bad_count, n_checks;
	assign strap_0 = cls0 == `STRAP_SCL ? scl : cls0 == `STRAP_SDA ? sda : cls0[0];
	assign strap_1 = cls1 == `STRAP_SCL ? scl : cls1 == `STRAP_SDA ? sda : cls1[0];
	assign rd_data = mem[reg_addr];
	always @(posedge sys_clk) if (wr_strobe) mem[reg_addr] <= wr_data;
	master_bfm i_master_bfm (.sda_oe(sda_oe), .scl(scl), .sda_line(sda));
	i2c_target_strap_address i_i2c_target_strap_address (
		.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .slave_id_strap_0(strap_0),
		.slave_id_strap_1(strap_1), .standalone_mode(standalone_mode),
		.session_active(session_active), .reg_addr(reg_addr),
		.wr_data(wr_data), .wr_strobe(wr_strobe), .rd_data(rd_data),
		.rd_strobe(rd_strobe));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic do_reset();
		nrst = 1'b0;
		repeat (20) @(posedge sys_clk);
		#1 nrst = 1'b1;
		repeat (12) @(posedge sys_clk);
		#1;
	endtask
	// Send a byte, release the ninth bit, compare the acknowledge
	task automatic wb(input logic [7:0] d, input logic exp_ack);
		i_master_bfm.xfer(d, 1'b1, r, a);
		check({7'h00, a}, {7'h00, exp_ack});
	endtask
	task automatic t_write();
		i_master_bfm.start();
		wb(8'hc6, 1'b1);
		wb(8'h10, 1'b1);
		wb(8'ha5, 1'b1);
		wb(8'h5a, 1'b1);
		i_master_bfm.stop();
		repeat (6) @(posedge sys_clk);
		check(mem[8'h10], 8'ha5);
		check(mem[8'h11], 8'h5a);
		check({7'h00, session_active}, 8'h00);
		$display("burst write finished");
	endtask
	task automatic t_read();
		i_master_bfm.start();
		wb(8'hc6, 1'b1);
		wb(8'h10, 1'b1);
		i_master_bfm.start();
		wb(8'hc7, 1'b1);
		i_master_bfm.xfer(8'hff, 1'b0, r, a);
		check(r, 8'ha5);
		i_master_bfm.xfer(8'hff, 1'b1, r, a);
		check(r, 8'h5a);
		i_master_bfm.stop();
		#1 check({7'h00, session_active}, 8'h00);
		$display("burst read finished");
	endtask
	task automatic t_miss();
		i_master_bfm.start();
		wb(8'hc4, 1'b0);
		wb(8'hc6, 1'b0);
		wb(8'h77, 1'b0);
		i_master_bfm.stop();
		check(mem[8'h12], 8'hxx);
		i_master_bfm.start();
		wb(8'hc6, 1'b1);
		wb(8'h12, 1'b1);
		wb(8'h3c, 1'b1);
		i_master_bfm.stop();
		repeat (6) @(posedge sys_clk);
		check(mem[8'h12], 8'h3c);
		$display("address mismatch finished");
	endtask
	task automatic t_alone();
		cls0 = `STRAP_GND;
		cls1 = `STRAP_GND;
		do_reset();
		check({7'h00, standalone_mode}, 8'h01);
		i_master_bfm.start();
		wb(8'hc6, 1'b0);
		i_master_bfm.stop();
		cls0 = `STRAP_RAIL;
		cls1 = `STRAP_RAIL;
		do_reset();
		check({7'h00, standalone_mode}, 8'h00);
		$display("stand-alone finished");
	endtask
	initial begin
		#100000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		bad_count = 0;
		n_checks = 0;
		cls0 = `STRAP_RAIL;
		cls1 = `STRAP_RAIL;
		do_reset();
		t_write();
		t_read();
		t_miss();
		t_alone();
		t_write();
		report_and_stop();
	end
endmodule // tb
